// ### gop_pkg.sv
// Constants and carrier types for the gauge option and alert-output block.
// Assumes one clock domain and that the option word is reached through plain ports.
package gop_pkg;

  // ----------------------------------------------------------------
  // Option word layout and reset value
  // ----------------------------------------------------------------
  localparam int unsigned OPT_RESERVE_COMP  = 7;
  localparam int unsigned OPT_RSVD          = 6;
  localparam int unsigned OPT_LOWBAT_SEL    = 5;
  localparam int unsigned OPT_SLEEP_EN      = 4;
  localparam int unsigned OPT_REMAIN_FULL   = 3;
  localparam int unsigned OPT_INSERT_PIN    = 2;
  localparam int unsigned OPT_POLARITY      = 1;
  localparam int unsigned OPT_HOST_TEMP     = 0;
  localparam logic [7:0]  OPT_RESET         = 8'h19;

  // ----------------------------------------------------------------
  // Charge thresholds in mAh
  // ----------------------------------------------------------------
  localparam logic [15:0] FIRST_SET_MAH     = 16'h0096;
  localparam logic [15:0] FIRST_CLR_MAH     = 16'h00af;
  localparam logic [15:0] FINAL_SET_MAH     = 16'h004b;
  localparam logic [15:0] FINAL_CLR_MAH     = 16'h0064;

  // ----------------------------------------------------------------
  // State divisors, scaled by ten: 13.3, 16.7 and 25.0
  // ----------------------------------------------------------------
  localparam logic [15:0] CHG_DIV_X10       = 16'h0085;
  localparam logic [15:0] DSG_DIV_X10       = 16'h00a7;
  localparam logic [15:0] RLX_DIV_X10       = 16'h00fa;
  localparam logic [15:0] DIV_SCALE         = 16'h000a;

  // ----------------------------------------------------------------
  // Percent boundaries
  // ----------------------------------------------------------------
  localparam logic [8:0]  PCT_FULL          = 9'h064;
  localparam logic [8:0]  PCT_FULL_M1       = 9'h063;
  localparam logic [7:0]  PCT_EMPTY         = 8'h00;

  // ----------------------------------------------------------------
  // Alert pulse timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_MHZ           = 250;
  localparam int unsigned PULSE_US          = 1000;
  localparam int unsigned PULSE_CYC         = PULSE_US * CLK_MHZ;

  // ----------------------------------------------------------------
  // Resistance tables
  // ----------------------------------------------------------------
  localparam int unsigned RA_TABLES         = 2;
  localparam int unsigned RA_ENTRIES        = 15;
  localparam logic [7:0]  RA_ST_OLD         = 8'h00;
  localparam logic [7:0]  RA_ST_DEFAULT     = 8'hff;
  localparam logic [7:0]  RA_ST_IN_USE      = 8'h55;
  localparam logic [15:0] RA_VAL_DEFAULT    = 16'h0066;

  // Power-up temperature in 0.1 K, about 25 C.
  localparam logic [15:0] TEMP_RESET        = 16'h0ba6;

  typedef enum logic [1:0] {
    GOP_RELAX     = 2'b00,
    GOP_CHARGE    = 2'b01,
    GOP_DISCHARGE = 2'b10
  } gop_batt_state_t;

  typedef struct packed {
    logic [15:0]        remaining;
    logic               remaining_upd;
    logic [15:0]        full_amount;
    logic signed [15:0] avg_current;
    logic [15:0]        design_cap;
    logic [7:0]         percent;
    logic               percent_upd;
  } gop_meas_t;

endpackage

// ### gop_option_alert.sv
// Option word, low-charge flags, battery state and the multiplexed alert pin.
// Assumes a synchronous system clock, measurements from the gauge core on the
// same clock, and an asynchronous insertion pin driven by the host.
`timescale 1ns/10ps

// Function
// - Eight-bit option word resets to 0x19, bit6 reserved.
// - Bit7 enables no-load rate compensation of reserve capacity.
// - Bit5 selects low-battery mirror, else charge-level pulses, on the pin.
// - Bit1 makes the pin active high, else active low.
// - Sleep is allowed only with bit4 set and conditions met.
// - Bit3 with valid termination loads remaining charge from full amount.
// - Bit2 takes insertion from the pin, else from the host command.
// - Bit0 lets the host write temperature, else the sensor supplies it.
// - Low-battery mode makes the pin track the first low-charge flag.
// - First low flag sets below 150 mAh, clears above 175 mAh.
// - Final low flag sets below 75 mAh, clears above 100 mAh.
// - In pulse mode a qualifying event starts a 1 ms pulse; events during it restart it.
// - Charging pulses when percent reaches a boundary from 100 down by step.
// - Discharging pulses when percent drops below a boundary, or reaches 0.
// - Nonzero step also pulses on every battery state change.
// - Pin detection enabled pulses when the pin signals removal.
// - State comes from average current against design capacity divisors.
// - Table status bytes: 0x00 old, 0xff default, 0x55 in use.
// - Two tables of 15 values reload to defaults on command.
module gop_option_alert
  import gop_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
  input  wire logic            clk_sys_i,
  input  wire logic            reset_i,
  input  wire logic            ce_i,
  input  wire logic            opt_wr_i,
  input  wire logic [7:0]      opt_wdata_i,
  input  wire logic [7:0]      pulse_step_size_i,
  input  wire gop_meas_t       meas_i,
  input  wire logic            charge_term_i,
  input  wire logic            sleep_cond_i,
  input  wire logic            insertion_detect_pin_i,
  input  wire logic            insert_notify_cmd_i,
  input  wire logic            remove_notify_cmd_i,
  input  wire logic            temp_wr_i,
  input  wire logic [15:0]     temp_wdata_i,
  input  wire logic [15:0]     temp_sensor_i,
  input  wire logic            defaults_reload_cmd_i,
  input  wire logic            ra_wr_i,
  input  wire logic            ra_sel_i,
  input  wire logic [3:0]      ra_idx_i,
  input  wire logic [15:0]     ra_wdata_i,
  output logic [7:0]           opt_o,
  output logic                 reserve_comp_enable_o,
  output logic                 sleep_allow_o,
  output logic [15:0]          remaining_charge_o,
  output logic                 first_low_charge_flag_o,
  output logic                 final_low_charge_flag_o,
  output logic [15:0]          temp_value_o,
  output gop_batt_state_t      batt_state_o,
  output logic                 battery_present_o,
  output logic                 multi_function_out_o,
  output logic [15:0]          ra_rdata_o,
  output logic [7:0]           ra_status0_o,
  output logic [7:0]           ra_status1_o
);

  // ----------------------------------------------------------------
  // Option word
  // ----------------------------------------------------------------
  logic [7:0] opt_r;
  wire  [7:0] opt_nxt = opt_wr_i ? opt_wdata_i : opt_r;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) opt_r <= OPT_RESET;
    else if (ce_i) opt_r <= opt_nxt;
  end

  // Bit6 is stored as written so that a host read-back matches what it wrote.
  wire lowbat_sel  = opt_r[OPT_LOWBAT_SEL];
  wire pin_detect  = opt_r[OPT_INSERT_PIN];
  wire step_nz     = (pulse_step_size_i != 8'h00);

  // ----------------------------------------------------------------
  // Insertion pin synchroniser
  // ----------------------------------------------------------------
  // The second and third stages must agree so a single-stage glitch is ignored.
  logic [2:0] bin_sync_r;
  logic       bin_level_r;
  wire        bin_agree  = (bin_sync_r[1] == bin_sync_r[2]);
  wire        bin_rise   = bin_agree & bin_sync_r[2] & ~bin_level_r;
  wire        bin_fall   = bin_agree & ~bin_sync_r[2] & bin_level_r;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      bin_sync_r  <= 3'h7;
      bin_level_r <= 1'b1;
    end else if (ce_i) begin
      bin_sync_r  <= {bin_sync_r[1:0], insertion_detect_pin_i};
      if (bin_agree) bin_level_r <= bin_sync_r[2];
    end
  end

  // ----------------------------------------------------------------
  // Battery presence
  // ----------------------------------------------------------------
  wire insert_ev  = pin_detect ? bin_fall : insert_notify_cmd_i;
  wire removal_ev = pin_detect ? bin_rise : remove_notify_cmd_i;
  // An insertion and a removal in one cycle leave the battery present.
  logic present_r;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) present_r <= 1'b0;
    else if (ce_i) begin
      if (insert_ev) present_r <= 1'b1;
      else if (removal_ev) present_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Remaining charge and low-charge flags
  // ----------------------------------------------------------------
  logic [15:0] rc_r;
  logic        first_r;
  logic        final_r;
  wire  [15:0] rc_nxt = (charge_term_i & opt_r[OPT_REMAIN_FULL]) ? meas_i.full_amount :
                        meas_i.remaining_upd ? meas_i.remaining : rc_r;
  wire first_nxt = (rc_r < FIRST_SET_MAH) ? 1'b1 : (rc_r > FIRST_CLR_MAH) ? 1'b0 : first_r;
  wire final_nxt = (rc_r < FINAL_SET_MAH) ? 1'b1 : (rc_r > FINAL_CLR_MAH) ? 1'b0 : final_r;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      rc_r    <= 16'h0000;
      first_r <= 1'b0;
      final_r <= 1'b0;
    end else if (ce_i) begin
      rc_r    <= rc_nxt;
      first_r <= first_nxt;
      final_r <= final_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Temperature source
  // ----------------------------------------------------------------
  // With host writes enabled the last written value holds until the next write.
  logic [15:0] temp_r;
  wire  [15:0] temp_nxt = opt_r[OPT_HOST_TEMP] ? (temp_wr_i ? temp_wdata_i : temp_r) :
                          temp_sensor_i;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) temp_r <= TEMP_RESET;
    else if (ce_i) temp_r <= temp_nxt;
  end

  // ----------------------------------------------------------------
  // Battery state from average current
  // ----------------------------------------------------------------
  // Division by the fractional divisors is replaced by cross-multiplying by ten.
  // Every factor is kept signed; one unsigned factor would turn a discharge
  // current into a huge positive product and read it as charging.
  wire signed [33:0] cur_x   = 34'(signed'(meas_i.avg_current));
  wire signed [33:0] cap_x10 = 34'(meas_i.design_cap) * 34'(DIV_SCALE);
  wire signed [33:0] chg_k   = 34'(CHG_DIV_X10);
  wire signed [33:0] dsg_k   = 34'(DSG_DIV_X10);
  wire signed [33:0] rlx_k   = 34'(RLX_DIV_X10);
  wire signed [33:0] abs_cur = cur_x[33] ? -cur_x : cur_x;
  wire is_chg = (cur_x * chg_k) > cap_x10;
  wire is_dsg = (-cur_x * dsg_k) > cap_x10;
  wire is_rlx = (abs_cur * rlx_k) < cap_x10;
  gop_batt_state_t state_r;
  gop_batt_state_t state_nxt;

  always_comb begin
    state_nxt = state_r;
    if (is_chg) state_nxt = GOP_CHARGE;
    else if (is_dsg) state_nxt = GOP_DISCHARGE;
    else if (is_rlx) state_nxt = GOP_RELAX;
  end

  wire state_change = (state_nxt != state_r);

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) state_r <= GOP_RELAX;
    else if (ce_i) state_r <= state_nxt;
  end

  // ----------------------------------------------------------------
  // Percent boundary crossings
  // ----------------------------------------------------------------
  // Counting boundaries above a percent turns each check into one divide.
  logic [7:0] pct_prev_r;
  wire  [8:0] step9    = {1'b0, pulse_step_size_i};
  wire  [8:0] stepd    = step_nz ? step9 : 9'h001;
  wire  [8:0] up_new   = PCT_FULL - {1'b0, meas_i.percent} + stepd - 9'h001;
  wire  [8:0] up_old   = PCT_FULL - {1'b0, pct_prev_r} + stepd - 9'h001;
  wire  [8:0] dn_new   = PCT_FULL_M1 - {1'b0, meas_i.percent};
  wire  [8:0] dn_old   = PCT_FULL_M1 - {1'b0, pct_prev_r};
  wire  [8:0] up_idx_n = up_new / stepd;
  wire  [8:0] up_idx_o = up_old / stepd;
  wire  [8:0] dn_idx_n = dn_new / stepd;
  wire  [8:0] dn_idx_o = dn_old / stepd;
  wire  rising  = meas_i.percent > pct_prev_r;
  wire  falling = meas_i.percent < pct_prev_r;
  wire  cross_up = rising & (up_idx_n < up_idx_o);
  wire  cross_dn = falling & ((meas_i.percent == PCT_EMPTY) |
                   ((pct_prev_r != PCT_FULL[7:0]) & (dn_idx_n > dn_idx_o)) |
                   (pct_prev_r == PCT_FULL[7:0]));
  wire  pct_ev  = meas_i.percent_upd & step_nz &
                  (((state_r == GOP_CHARGE) & cross_up) | ((state_r == GOP_DISCHARGE) & cross_dn));

  // The previous percent only moves on an update, so a steady reading never fires twice.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) pct_prev_r <= 8'h00;
    else if (ce_i && meas_i.percent_upd) pct_prev_r <= meas_i.percent;
  end

  // ----------------------------------------------------------------
  // Alert pulse and pin
  // ----------------------------------------------------------------
  // Events that overlap a running pulse restart it; the pin shows one longer pulse.
  localparam int unsigned PW = $clog2(PULSE_CYCLES + 1);
  logic [PW-1:0] pulse_cnt_r;
  wire  pulse_ev = pct_ev | (step_nz & state_change) | (pin_detect & bin_rise);
  wire  [PW-1:0] pulse_cnt_nxt = pulse_ev ? PW'(PULSE_CYCLES) :
                                 (pulse_cnt_r != '0) ? pulse_cnt_r - PW'(1) : pulse_cnt_r;
  wire  active_lvl = lowbat_sel ? first_r : (pulse_cnt_r != '0);
  wire  pin_nxt    = opt_r[OPT_POLARITY] ? active_lvl : ~active_lvl;

  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      pulse_cnt_r          <= '0;
      multi_function_out_o <= 1'b1;
    end else if (ce_i) begin
      pulse_cnt_r          <= pulse_cnt_nxt;
      multi_function_out_o <= pin_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Resistance tables
  // ----------------------------------------------------------------
  logic [15:0] ra_val_r [RA_TABLES*RA_ENTRIES];
  logic [7:0]  ra_st_r  [RA_TABLES];
  wire  [4:0]  ra_addr = 5'(ra_sel_i ? RA_ENTRIES : 0) + 5'(ra_idx_i);
  wire         ra_ok   = (ra_idx_i < 4'(RA_ENTRIES));

  genvar g;
  generate
    for (g = 0; g < RA_TABLES * RA_ENTRIES; g++) begin : g_ra
      always_ff @(posedge clk_sys_i) begin
        if (reset_i || (ce_i && defaults_reload_cmd_i)) ra_val_r[g] <= RA_VAL_DEFAULT;
        else if (ce_i && ra_wr_i && ra_ok && (ra_addr == 5'(g))) ra_val_r[g] <= ra_wdata_i;
      end
    end
  endgenerate

  // Table 0 is the one in use; a written spare table becomes previously updated.
  always_ff @(posedge clk_sys_i) begin
    if (reset_i || (ce_i && defaults_reload_cmd_i)) begin
      ra_st_r[0] <= RA_ST_IN_USE;
      ra_st_r[1] <= RA_ST_DEFAULT;
    end else if (ce_i && ra_wr_i && ra_ok && ra_sel_i) begin
      ra_st_r[1] <= RA_ST_OLD;
    end
  end

  // ----------------------------------------------------------------
  // Registered outputs
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (reset_i) begin
      opt_o                   <= OPT_RESET;
      reserve_comp_enable_o   <= 1'b0;
      sleep_allow_o           <= 1'b0;
      remaining_charge_o      <= 16'h0000;
      first_low_charge_flag_o <= 1'b0;
      final_low_charge_flag_o <= 1'b0;
      temp_value_o            <= TEMP_RESET;
      batt_state_o            <= GOP_RELAX;
      battery_present_o       <= 1'b0;
      ra_rdata_o              <= 16'h0000;
      ra_status0_o            <= RA_ST_IN_USE;
      ra_status1_o            <= RA_ST_DEFAULT;
    end else if (ce_i) begin
      opt_o                   <= opt_r;
      reserve_comp_enable_o   <= opt_r[OPT_RESERVE_COMP];
      sleep_allow_o           <= opt_r[OPT_SLEEP_EN] & sleep_cond_i;
      remaining_charge_o      <= rc_r;
      first_low_charge_flag_o <= first_r;
      final_low_charge_flag_o <= final_r;
      temp_value_o            <= temp_r;
      batt_state_o            <= state_r;
      battery_present_o       <= present_r;
      ra_rdata_o              <= ra_ok ? ra_val_r[ra_addr] : 16'h0000;
      ra_status0_o            <= ra_st_r[0];
      ra_status1_o            <= ra_st_r[1];
    end
  end

endmodule

// ### gop_option_alert_assertions.sv
// Concurrent checks on the ports of the option and alert block.
// Assumes ce_i stays high wherever flag and pulse timing are judged.
`timescale 1ns/10ps
module gop_option_alert_assertions
  import gop_pkg::*;
#(
  parameter int unsigned PULSE_CYCLES = PULSE_CYC
) (
  input wire logic        clk_sys_i,
  input wire logic        reset_i,
  input wire logic        ce_i,
  input wire logic        opt_wr_i,
  input wire logic [7:0]  opt_wdata_i,
  input wire gop_meas_t   meas_i,
  input wire logic        charge_term_i,
  input wire logic        sleep_cond_i,
  input wire logic [7:0]  opt_o,
  input wire logic        reserve_comp_enable_o,
  input wire logic        sleep_allow_o,
  input wire logic [15:0] remaining_charge_o,
  input wire logic        first_low_charge_flag_o,
  input wire logic        final_low_charge_flag_o,
  input wire logic        multi_function_out_o
);
  // ----------------------------------------------------------------
  // Properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (reset_i);
  wire         act_w = (multi_function_out_o == opt_o[OPT_POLARITY]);
  int unsigned run_r;
  // Length of the active stretch so far; a restarted pulse only makes it longer.
  always_ff @(posedge clk_sys_i) begin
    run_r <= (reset_i || !act_w) ? '0 : run_r + 1;
  end
  sequence s_opt;
    ce_i && opt_wr_i ##1 ce_i;
  endsequence
  sequence s_rem;
    ce_i && meas_i.remaining_upd && !charge_term_i ##1 ce_i;
  endsequence
  sequence s_term;
    ce_i && charge_term_i && opt_o[OPT_REMAIN_FULL] && !$past(opt_wr_i) ##1 ce_i;
  endsequence
  property p_opt;
    s_opt |=> opt_o == $past(opt_wdata_i, 2);
  endproperty
  property p_rc;
    reserve_comp_enable_o == opt_o[OPT_RESERVE_COMP];
  endproperty
  property p_sleep;
    !$past(reset_i) |-> sleep_allow_o == (opt_o[OPT_SLEEP_EN] && $past(sleep_cond_i));
  endproperty
  property p_rem;
    s_rem |=> remaining_charge_o == $past(meas_i.remaining, 2);
  endproperty
  property p_term;
    s_term |=> remaining_charge_o == $past(meas_i.full_amount, 2);
  endproperty
  property p_first;
    !$past(reset_i) |=> first_low_charge_flag_o == ($past(remaining_charge_o) < FIRST_SET_MAH ? 1'b1 :
      $past(remaining_charge_o) > FIRST_CLR_MAH ? 1'b0 : $past(first_low_charge_flag_o));
  endproperty
  property p_final;
    !$past(reset_i) |=> final_low_charge_flag_o == ($past(remaining_charge_o) < FINAL_SET_MAH ? 1'b1 :
      $past(remaining_charge_o) > FINAL_CLR_MAH ? 1'b0 : $past(final_low_charge_flag_o));
  endproperty
  property p_lowbat;
    opt_o[OPT_LOWBAT_SEL] |-> act_w == first_low_charge_flag_o;
  endproperty
  property p_pulse;
    $fell(act_w) && !opt_o[OPT_LOWBAT_SEL] && !$past(opt_o[OPT_LOWBAT_SEL]) && $stable(opt_o[OPT_POLARITY])
      |-> run_r >= PULSE_CYCLES;
  endproperty
  a_opt: assert property (p_opt) else $error("option word not shown two cycles after write");
  a_rc: assert property (p_rc) else $error("reserve compensation differs from option bit");
  a_sleep: assert property (p_sleep) else $error("sleep permission wrong");
  a_rem: assert property (p_rem) else $error("remaining charge not loaded");
  a_term: assert property (p_term) else $error("termination did not copy full amount");
  a_first: assert property (p_first) else $error("first low flag wrong");
  a_final: assert property (p_final) else $error("final low flag wrong");
  a_lowbat: assert property (p_lowbat) else $error("alert pin does not mirror low flag");
  a_pulse: assert property (p_pulse) else $error("alert pulse too short");
endmodule

bind gop_option_alert gop_option_alert_assertions #(.PULSE_CYCLES(PULSE_CYCLES)) u_gop_option_alert_assertions (
  .clk_sys_i, .reset_i, .ce_i, .opt_wr_i, .opt_wdata_i, .meas_i, .charge_term_i, .sleep_cond_i, .opt_o,
  .reserve_comp_enable_o, .sleep_allow_o, .remaining_charge_o, .first_low_charge_flag_o,
  .final_low_charge_flag_o, .multi_function_out_o
);

// ### gop_host_model.sv
// Host-side model: drives the insertion pin and counts active alert cycles.
// Assumes it is told the alert polarity that the host programmed.
`timescale 1ns/10ps
module gop_host_model (
  input  wire logic clk_sys_i,
  input  wire logic multi_function_out_i,
  input  wire logic polarity_i,
  output logic      insertion_detect_pin_o
);
  // ----------------------------------------------------------------
  // Pin driver and alert counter
  // ----------------------------------------------------------------
  int unsigned act_cnt;
  initial begin
    act_cnt = 0;
    insertion_detect_pin_o = 1'b1;
  end
  // The pin is judged on the falling edge, where it has settled after its launch.
  always @(negedge clk_sys_i) begin
    if (multi_function_out_i === polarity_i)
      act_cnt++;
  end
  // Low means a battery is in; rising back to high means it was taken out.
  task automatic set_pin(input logic v);
    @(posedge clk_sys_i);
    #1 insertion_detect_pin_o = v;
  endtask
endmodule

// ### gop_option_alert_tb.sv
// Self-checking bench for the option and alert block.
// Assumes the host model beside it drives the insertion pin.
`timescale 1ns/10ps
module gop_option_alert_tb
  import gop_pkg::*;
;
  // ----------------------------------------------------------------
  // Signals, tasks and test sequence
  // ----------------------------------------------------------------
  logic clk_sys_i, reset_i, ce_i, opt_wr_i, charge_term_i, sleep_cond_i, insert_notify_cmd_i;
  logic remove_notify_cmd_i, temp_wr_i, defaults_reload_cmd_i, ra_wr_i, ra_sel_i;
  logic reserve_comp_enable_o, sleep_allow_o, first_low_charge_flag_o, final_low_charge_flag_o;
  logic battery_present_o, multi_function_out_o;
  logic [7:0]      opt_wdata_i, pulse_step_size_i, opt_o, ra_status0_o, ra_status1_o;
  logic [3:0]      ra_idx_i;
  logic [15:0]     temp_wdata_i, temp_sensor_i, ra_wdata_i, remaining_charge_o, temp_value_o, ra_rdata_o;
  wire logic       insertion_detect_pin_i;
  gop_meas_t       meas_i;
  gop_batt_state_t batt_state_o;
  int              n_fail, checked, n0;
  logic [15:0]     rem_tab [6] = '{16'h0095, 16'h00a0, 16'h00b0, 16'h004a, 16'h005a, 16'h0065};
  logic [5:0]      f1_tab = 6'b111011;
  logic [5:0]      f2_tab = 6'b011000;
  // Short pulse keeps the run brief; every pulse expectation uses it.
  gop_option_alert #(.PULSE_CYCLES(8)) u_gop_option_alert (.clk_sys_i, .reset_i, .ce_i, .opt_wr_i,
    .opt_wdata_i, .pulse_step_size_i, .meas_i, .charge_term_i, .sleep_cond_i, .insertion_detect_pin_i,
    .insert_notify_cmd_i, .remove_notify_cmd_i, .temp_wr_i, .temp_wdata_i, .temp_sensor_i,
    .defaults_reload_cmd_i, .ra_wr_i, .ra_sel_i, .ra_idx_i, .ra_wdata_i, .opt_o, .reserve_comp_enable_o,
    .sleep_allow_o, .remaining_charge_o, .first_low_charge_flag_o, .final_low_charge_flag_o, .temp_value_o,
    .batt_state_o, .battery_present_o, .multi_function_out_o, .ra_rdata_o, .ra_status0_o, .ra_status1_o);
  gop_host_model u_gop_host_model (.clk_sys_i, .multi_function_out_i(multi_function_out_o),
    .polarity_i(opt_o[OPT_POLARITY]), .insertion_detect_pin_o(insertion_detect_pin_i));
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic chk(input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e) begin
      n_fail++;
      $display("BAD t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic wr_opt(input logic [7:0] v);
    opt_wdata_i = v;
    opt_wr_i = 1'b1;
    cyc(1);
    opt_wr_i = 1'b0;
    cyc(3);
  endtask
  task automatic set_rem(input logic [15:0] v);
    meas_i.remaining = v;
    meas_i.remaining_upd = 1'b1;
    cyc(1);
    meas_i.remaining_upd = 1'b0;
    cyc(4);
  endtask
  task automatic pct(input logic [7:0] v);
    meas_i.percent = v;
    meas_i.percent_upd = 1'b1;
    cyc(1);
    meas_i.percent_upd = 1'b0;
  endtask
  // Counts active alert cycles seen by the host over a window.
  task automatic pulses(input int win, input int e);
    n0 = u_gop_host_model.act_cnt;
    cyc(win);
    chk(16'(u_gop_host_model.act_cnt - n0), 16'(e));
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys_i = 1'b0;
    forever #2 clk_sys_i = ~clk_sys_i;
  end
  initial begin
    repeat (5000) @(posedge clk_sys_i);
    n_fail++;
    final_report();
  end
  initial begin
    {reset_i, ce_i, sleep_cond_i} = 3'b111;
    {opt_wr_i, charge_term_i, insert_notify_cmd_i, remove_notify_cmd_i, temp_wr_i} = 5'h00;
    {defaults_reload_cmd_i, ra_wr_i, ra_sel_i, ra_idx_i} = 7'h00;
    {opt_wdata_i, pulse_step_size_i} = 16'h0000;
    {temp_wdata_i, temp_sensor_i, ra_wdata_i} = {16'h0000, 16'h0bbb, 16'h0000};
    n_fail = 0;
    checked = 0;
    meas_i = '0;
    meas_i.design_cap = 16'h03e8;
    cyc(3);
    reset_i = 1'b0;
    chk(16'(opt_o), 16'h0019);
    chk(16'(multi_function_out_o), 16'h0001);
    chk(temp_value_o, TEMP_RESET);
    chk({ra_status0_o, ra_status1_o}, 16'h55ff);
    chk(16'(batt_state_o), 16'(GOP_RELAX));
    wr_opt(8'hc0);
    chk(16'(opt_o), 16'h00c0);
    chk(16'(reserve_comp_enable_o), 16'h0001);
    wr_opt(8'h10);
    chk(16'({reserve_comp_enable_o, sleep_allow_o}), 16'h0001);
    wr_opt(8'h01);
    chk(16'(sleep_allow_o), 16'h0000);
    temp_wdata_i = 16'h1234;
    temp_wr_i = 1'b1;
    cyc(1);
    temp_wr_i = 1'b0;
    cyc(3);
    chk(temp_value_o, 16'h1234);
    wr_opt(8'h08);
    chk(temp_value_o, 16'h0bbb);
    meas_i.full_amount = 16'h01f4;
    charge_term_i = 1'b1;
    cyc(1);
    charge_term_i = 1'b0;
    cyc(3);
    chk(remaining_charge_o, 16'h01f4);
    wr_opt(8'h00);
    meas_i.full_amount = 16'h0258;
    charge_term_i = 1'b1;
    cyc(1);
    charge_term_i = 1'b0;
    cyc(3);
    chk(remaining_charge_o, 16'h01f4);
    wr_opt(8'h20);
    for (int i = 0; i < 6; i++) begin
      set_rem(rem_tab[i]);
      chk(16'({first_low_charge_flag_o, final_low_charge_flag_o}), 16'({f1_tab[i], f2_tab[i]}));
      chk(16'(multi_function_out_o), 16'(!f1_tab[i]));
    end
    wr_opt(8'h22);
    chk(16'(multi_function_out_o), 16'h0001);
    set_rem(16'h00b4);
    chk(16'(multi_function_out_o), 16'h0000);
    wr_opt(8'h06);
    chk(16'(multi_function_out_o), 16'h0000);
    pulse_step_size_i = 8'h0a;
    meas_i.avg_current = 16'h00c8;
    pulses(14, 8);
    chk(16'(batt_state_o), 16'(GOP_CHARGE));
    pct(8'h55);
    pulses(14, 8);
    pct(8'h59);
    pulses(14, 0);
    pct(8'h5a);
    pulses(14, 8);
    meas_i.avg_current = 16'hff38;
    pulses(14, 8);
    chk(16'(batt_state_o), 16'(GOP_DISCHARGE));
    pct(8'h59);
    pulses(14, 8);
    pct(8'h55);
    pulses(14, 0);
    pulse_step_size_i = 8'h00;
    meas_i.avg_current = 16'h0000;
    pulses(14, 0);
    chk(16'(batt_state_o), 16'(GOP_RELAX));
    u_gop_host_model.set_pin(1'b0);
    cyc(10);
    chk(16'(battery_present_o), 16'h0001);
    u_gop_host_model.set_pin(1'b1);
    pulses(22, 8);
    chk(16'(battery_present_o), 16'h0000);
    wr_opt(8'h02);
    insert_notify_cmd_i = 1'b1; // Host announces the battery itself while the pin is ignored.
    cyc(1);
    insert_notify_cmd_i = 1'b0;
    cyc(4);
    chk(16'(battery_present_o), 16'h0001);
    remove_notify_cmd_i = 1'b1;
    cyc(1);
    remove_notify_cmd_i = 1'b0;
    cyc(4);
    chk(16'(battery_present_o), 16'h0000);
    {ra_sel_i, ra_idx_i, ra_wdata_i, ra_wr_i} = {1'b1, 4'h3, 16'h0abc, 1'b1};
    cyc(1);
    ra_wr_i = 1'b0;
    cyc(3);
    chk(ra_rdata_o, 16'h0abc);
    chk(16'(ra_status1_o), 16'(RA_ST_OLD));
    ra_idx_i = 4'hf;
    cyc(3);
    chk(ra_rdata_o, 16'h0000);
    ra_idx_i = 4'h3;
    defaults_reload_cmd_i = 1'b1;
    cyc(1);
    defaults_reload_cmd_i = 1'b0;
    cyc(3);
    chk(ra_rdata_o, 16'h0066);
    chk({ra_status0_o, ra_status1_o}, 16'h55ff);
    final_report();
  end
endmodule
